// [hdl/ast_pkg.sv]
// Constants, register map and state type of the asynchronous serial transmitter
// Function
// - Line rests at mark level whenever no character is being sent.
// - Frame is one space start bit, eight or nine data bits, mark stop bit.
// - Every bit on the line lasts exactly one baud period.
// - Baud rate comes from system clock through an 8-bit divisor, shared format.
// - Data bits go out least significant first; no hardware parity.
// - Sending runs only with transmit enable set, clocked mode clear, port enabled.
// - Port enable forces transmit pin to output and receive pin to input.
// - Holding register write starts sending; empty shifter loads it at once.
// - Busy shifter: character waits, loads within one instruction cycle after stop.
// - Buffer-empty flag set when enabled and nothing queued; clear when queued or transmit enable clear.
// - Buffer-empty flag shows new state once two instruction cycles after write have passed.
// - Buffer-empty flag read-only, set by transmit enable, ignores its irq enable.
// - Interrupt when flag, its enable, global and peripheral gates all set.
// - Shifter-empty flag read-only, clear from load until last bit, no interrupt.
// - Nine-bit mode sends ninth register bit as MSB, loaded with the write.
// - Reset leaves control/status reading only shifter-empty set, divisor zero.
package ast_pkg;

  // Word-aligned byte offsets on the bus
  localparam logic [7:0] OFS_TX_CTRL_STATUS = 8'h00;
  localparam logic [7:0] OFS_RX_CTRL_STATUS = 8'h04;
  localparam logic [7:0] OFS_BAUD_DIVISOR = 8'h08;
  localparam logic [7:0] OFS_TX_HOLDING = 8'h0c;
  localparam logic [7:0] OFS_PERIPH_FLAGS = 8'h10;
  localparam logic [7:0] OFS_PERIPH_IRQ_EN = 8'h14;
  localparam logic [7:0] OFS_IRQ_GATES = 8'h18;

  // Bit positions
  localparam int B_NINE_BIT_SEL = 6;
  localparam int B_TRANSMIT_EN = 5;
  localparam int B_CLOCKED_MODE = 4;
  localparam int B_BAUD_HIGH = 2;
  localparam int B_SHIFTER_EMPTY = 1;
  localparam int B_NINTH_BIT = 0;
  localparam int B_PORT_EN = 7;
  localparam int B_TX_BUF_FLAG = 4;
  localparam int B_GLOBAL_IRQ = 7;
  localparam int B_PERIPH_GATE = 6;

  // Reset values and writable masks
  localparam logic [7:0] TX_CTRL_RST = 8'h02;
  localparam logic [7:0] TX_CTRL_WMASK = 8'hf5;
  localparam logic [7:0] RX_CTRL_RST = 8'h00;
  localparam logic [7:0] RX_CTRL_WMASK = 8'hf8;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] HOLD_RST = 8'h00;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [7:0] GATES_RST = 8'h00;
  localparam logic [7:0] GATES_WMASK = 8'hc0;
  localparam logic [7:0] FLAG_TXBUF_MASK = 8'h10;

  // Baud prescale: clocks per divisor step, low and high speed
  localparam logic [6:0] PRESC_LOW_M1 = 7'h3f;
  localparam logic [6:0] PRESC_HIGH_M1 = 7'h0f;

  // Data bits per frame
  localparam logic [3:0] DATA_BITS_STD = 4'h8;
  localparam logic [3:0] DATA_BITS_NINE = 4'h9;

  // Instruction cycle and buffer-flag settling time
  localparam int CLK_PERIOD_NS = 8;
  localparam int TCY_NS = 32;
  localparam int TCY_CYCLES = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLAG_SETTLE_TCY = 2;
  localparam logic [3:0] FLAG_SETTLE_M1 = 4'(FLAG_SETTLE_TCY * TCY_CYCLES - 1);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b10,
    ST_STOP = 2'b11
  } ast_state_e;

endpackage : ast_pkg

// [hdl/ast_transmitter.sv]
// Asynchronous serial transmitter with classic Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module ast_transmitter (
  input wire logic mclk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic transmit_pin_out,
  output logic transmit_pin_oe,
  output logic receive_pin_oe,
  output logic tx_irq
);

  // Registers
  logic [7:0] tx_ctrl_status_ff;
  logic [7:0] rx_ctrl_status_ff;
  logic [7:0] baud_divisor_ff;
  logic [7:0] tx_holding_reg_ff;
  logic ninth_hold_ff;
  logic hold_full_ff;
  logic [7:0] periph_irq_enable_one_ff;
  logic [7:0] irq_gates_ff;
  ast_pkg::ast_state_e state_ff;
  logic [8:0] tx_shift_reg_ff;
  logic [3:0] nbits_ff;
  logic [3:0] bitcnt_ff;
  logic [6:0] pre_ff;
  logic [7:0] brg_ff;
  logic tx_out_ff;
  logic tx_oe_ff;
  logic rx_oe_ff;
  logic tx_buffer_empty_flag_ff;
  logic [3:0] settle_ff;
  logic irq_ff;
  logic ack_ff;
  logic [31:0] dat_ff;

  // Bus decode
  wire wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  wire hit_txcs = wb_adr_i[7:2] == ast_pkg::OFS_TX_CTRL_STATUS[7:2];
  wire hit_rxcs = wb_adr_i[7:2] == ast_pkg::OFS_RX_CTRL_STATUS[7:2];
  wire hit_baud = wb_adr_i[7:2] == ast_pkg::OFS_BAUD_DIVISOR[7:2];
  wire hit_hold = wb_adr_i[7:2] == ast_pkg::OFS_TX_HOLDING[7:2];
  wire hit_flags = wb_adr_i[7:2] == ast_pkg::OFS_PERIPH_FLAGS[7:2];
  wire hit_irqen = wb_adr_i[7:2] == ast_pkg::OFS_PERIPH_IRQ_EN[7:2];
  wire hit_gates = wb_adr_i[7:2] == ast_pkg::OFS_IRQ_GATES[7:2];
  wire wr_hold = wb_wr & hit_hold;

  // Control bits
  wire transmit_enable = tx_ctrl_status_ff[ast_pkg::B_TRANSMIT_EN];
  wire clocked_mode = tx_ctrl_status_ff[ast_pkg::B_CLOCKED_MODE];
  wire port_enable = rx_ctrl_status_ff[ast_pkg::B_PORT_EN];
  wire nine_bit_tx_select = tx_ctrl_status_ff[ast_pkg::B_NINE_BIT_SEL];
  wire ninth_tx_bit = tx_ctrl_status_ff[ast_pkg::B_NINTH_BIT];
  wire baud_high_speed = tx_ctrl_status_ff[ast_pkg::B_BAUD_HIGH];
  wire tx_buffer_irq_enable = periph_irq_enable_one_ff[ast_pkg::B_TX_BUF_FLAG];
  wire global_irq_enable = irq_gates_ff[ast_pkg::B_GLOBAL_IRQ];
  wire periph_irq_gate = irq_gates_ff[ast_pkg::B_PERIPH_GATE];

  // Async transmission only in this exact mode
  wire run = transmit_enable & ~clocked_mode & port_enable;
  wire shifter_empty_flag = state_ff == ast_pkg::ST_IDLE;

  // Baud generator: presc * (divisor + 1) clocks per bit
  wire [6:0] presc_m1 = baud_high_speed ? ast_pkg::PRESC_HIGH_M1 : ast_pkg::PRESC_LOW_M1;
  wire pre_wrap = pre_ff == presc_m1;
  wire bit_tick = pre_wrap & (brg_ff == baud_divisor_ff);
  wire counting = run & (state_ff != ast_pkg::ST_IDLE);
  wire [6:0] nxt_pre = (~counting | pre_wrap) ? 7'h00 : 7'(pre_ff + 7'h01);
  wire [7:0] nxt_brg = (~counting | bit_tick) ? 8'h00 :
                       pre_wrap ? 8'(brg_ff + 8'h01) : brg_ff;

  // Loading the shifter: idle with a character waiting, or right at stop end
  wire load_idle = run & shifter_empty_flag & hold_full_ff;
  wire load_stop = run & (state_ff == ast_pkg::ST_STOP) & bit_tick & hold_full_ff;
  wire load = load_idle | load_stop;
  wire last_data = bitcnt_ff == 4'(nbits_ff - 4'h1);

  ast_pkg::ast_state_e nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ast_pkg::ST_IDLE: begin
        if (load_idle) begin
          nxt_state = ast_pkg::ST_START;
        end
      end
      ast_pkg::ST_START: begin
        if (bit_tick) begin
          nxt_state = ast_pkg::ST_DATA;
        end
      end
      ast_pkg::ST_DATA: begin
        if (bit_tick & last_data) begin
          nxt_state = ast_pkg::ST_STOP;
        end
      end
      ast_pkg::ST_STOP: begin
        if (bit_tick) begin
          nxt_state = load_stop ? ast_pkg::ST_START : ast_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = ast_pkg::ST_IDLE;
      end
    endcase
    // Losing the enable aborts the frame in progress
    if (!run) begin
      nxt_state = ast_pkg::ST_IDLE;
    end
  end

  // Shift right so bit 0 leaves first ninth bit is the MSB
  wire [8:0] nxt_shift = load ? {ninth_hold_ff, tx_holding_reg_ff} :
                         (state_ff == ast_pkg::ST_DATA && bit_tick) ?
                         {1'b0, tx_shift_reg_ff[8:1]} : tx_shift_reg_ff;
  wire [3:0] nxt_nbits = load ? (nine_bit_tx_select ? ast_pkg::DATA_BITS_NINE :
                                 ast_pkg::DATA_BITS_STD) : nbits_ff;
  wire [3:0] nxt_bitcnt = (state_ff == ast_pkg::ST_DATA && bit_tick) ? 4'(bitcnt_ff + 4'h1) :
                          (state_ff == ast_pkg::ST_DATA) ? bitcnt_ff : 4'h0;

  // Line level follows next state so pin and state agree each cycle
  wire nxt_tx_out = (nxt_state == ast_pkg::ST_START) ? 1'b0 :
                    (nxt_state == ast_pkg::ST_DATA) ? nxt_shift[0] : 1'b1;

  // Write sets the holding flag and wins over a same-cycle load; port off drops it
  wire nxt_hold_full = ~port_enable ? 1'b0 : wr_hold ? 1'b1 : load ? 1'b0 : hold_full_ff;

  // Buffer-empty flag: live value, frozen for two instruction cycles after a write
  wire tx_buffer_empty_flag_live = transmit_enable & ~hold_full_ff;
  wire nxt_tx_buffer_empty_flag = (settle_ff != 4'h0) ? tx_buffer_empty_flag_ff : tx_buffer_empty_flag_live;
  wire [3:0] nxt_settle = wr_hold ? ast_pkg::FLAG_SETTLE_M1 :
                          (settle_ff != 4'h0) ? 4'(settle_ff - 4'h1) : 4'h0;
  wire nxt_irq = tx_buffer_empty_flag_ff & tx_buffer_irq_enable & global_irq_enable & periph_irq_gate;

  // Register read mux; unmapped offsets read zero and still ack
  wire [7:0] tx_ctrl_rd = {tx_ctrl_status_ff[7:2], shifter_empty_flag, tx_ctrl_status_ff[0]};
  wire [7:0] flags_rd = ast_pkg::FLAG_TXBUF_MASK & {8{tx_buffer_empty_flag_ff}};
  wire [7:0] rd_byte = hit_txcs ? tx_ctrl_rd :
                       hit_rxcs ? rx_ctrl_status_ff :
                       hit_baud ? baud_divisor_ff :
                       hit_hold ? tx_holding_reg_ff :
                       hit_flags ? flags_rd :
                       hit_irqen ? periph_irq_enable_one_ff :
                       hit_gates ? irq_gates_ff : 8'h00;
  wire [7:0] wdat = wb_dat_i[7:0];

  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_ctrl_status_ff <= ast_pkg::TX_CTRL_RST & ast_pkg::TX_CTRL_WMASK;
      rx_ctrl_status_ff <= ast_pkg::RX_CTRL_RST;
      baud_divisor_ff <= ast_pkg::BAUD_RST;
      periph_irq_enable_one_ff <= ast_pkg::IRQ_EN_RST;
      irq_gates_ff <= ast_pkg::GATES_RST;
    end else if (wb_wr) begin
      if (hit_txcs) begin
        tx_ctrl_status_ff <= wdat & ast_pkg::TX_CTRL_WMASK;
      end
      if (hit_rxcs) begin
        rx_ctrl_status_ff <= wdat & ast_pkg::RX_CTRL_WMASK;
      end
      if (hit_baud) begin
        baud_divisor_ff <= wdat;
      end
      if (hit_irqen) begin
        periph_irq_enable_one_ff <= wdat;
      end
      if (hit_gates) begin
        irq_gates_ff <= wdat & ast_pkg::GATES_WMASK;
      end
    end
  end

  // Ninth bit captured with the data so both move together
  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_holding_reg_ff <= ast_pkg::HOLD_RST;
      ninth_hold_ff <= 1'b0;
    end else if (wr_hold) begin
      tx_holding_reg_ff <= wdat;
      ninth_hold_ff <= ninth_tx_bit;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= ast_pkg::ST_IDLE;
      tx_shift_reg_ff <= 9'h000;
      nbits_ff <= ast_pkg::DATA_BITS_STD;
      bitcnt_ff <= 4'h0;
      pre_ff <= 7'h00;
      brg_ff <= 8'h00;
      hold_full_ff <= 1'b0;
      tx_out_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      tx_shift_reg_ff <= nxt_shift;
      nbits_ff <= nxt_nbits;
      bitcnt_ff <= nxt_bitcnt;
      pre_ff <= nxt_pre;
      brg_ff <= nxt_brg;
      hold_full_ff <= nxt_hold_full;
      tx_out_ff <= nxt_tx_out;
    end
  end

  // Pin direction forced by the port enable
  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_oe_ff <= 1'b0;
      rx_oe_ff <= 1'b0;
    end else begin
      tx_oe_ff <= port_enable;
      rx_oe_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_buffer_empty_flag_ff <= 1'b0;
      settle_ff <= 4'h0;
      irq_ff <= 1'b0;
    end else begin
      tx_buffer_empty_flag_ff <= nxt_tx_buffer_empty_flag;
      settle_ff <= nxt_settle;
      irq_ff <= nxt_irq;
    end
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge mclk) begin
    if (reset) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= wb_req;
      dat_ff <= wb_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Cycles spent on the current bit, checked against the divisor setting
  logic [14:0] dwell_ff;
  wire [14:0] bit_len_m1 = 15'(({8'h00, presc_m1} + 15'h0001) *
                           ({7'h00, baud_divisor_ff} + 15'h0001) - 15'h0001);
  wire [14:0] nxt_dwell = (bit_tick | (nxt_state != state_ff)) ? 15'h0000 :
                          15'(dwell_ff + 15'h0001);

  always_ff @(posedge mclk) begin
    if (reset) begin
      dwell_ff <= 15'h0000;
    end else begin
      dwell_ff <= nxt_dwell;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign transmit_pin_out = tx_out_ff;
  assign transmit_pin_oe = tx_oe_ff;
  assign receive_pin_oe = rx_oe_ff;
  assign tx_irq = irq_ff;

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  sequence frame_load_s;
    state_ff == ast_pkg::ST_IDLE && hold_full_ff && run;
  endsequence

  sequence frame_start_s;
    state_ff == ast_pkg::ST_START && !shifter_empty_flag && tx_out_ff == 1'b0;
  endsequence

  sequence stop_end_s;
    state_ff == ast_pkg::ST_STOP && bit_tick && hold_full_ff && run;
  endsequence

  idle_line_mark_a: assert property (
    state_ff == ast_pkg::ST_IDLE |-> tx_out_ff == 1'b1)
    else $error("line not at mark while idle");

  frame_levels_a: assert property (
    (state_ff == ast_pkg::ST_START |-> tx_out_ff == 1'b0) and
    (state_ff == ast_pkg::ST_STOP |-> tx_out_ff == 1'b1))
    else $error("start or stop bit at wrong level");

  bit_on_tick_a: assert property (
    $past(state_ff) != ast_pkg::ST_IDLE && $past(run) && state_ff != $past(state_ff)
    |-> $past(bit_tick))
    else $error("bit changed before its baud period ended");

  lsb_first_a: assert property (
    state_ff == ast_pkg::ST_DATA |-> tx_out_ff == tx_shift_reg_ff[0])
    else $error("data bit not the shifter low bit");

  pin_direction_a: assert property (
    port_enable |=> transmit_pin_oe && !receive_pin_oe)
    else $error("pin direction not forced by port enable");

  empty_load_a: assert property (
    frame_load_s |=> frame_start_s)
    else $error("waiting character not loaded from idle");

  back_to_back_a: assert property (
    stop_end_s |=> frame_start_s)
    else $error("queued character not started after stop");

  flag_follows_a: assert property (
    settle_ff == 4'h0 && $past(settle_ff) == 4'h0
    |-> tx_buffer_empty_flag_ff == $past(transmit_enable && !hold_full_ff))
    else $error("buffer flag not tracking holding state");

  flag_settle_a: assert property (
    wr_hold |=> $stable(tx_buffer_empty_flag_ff)[*8])
    else $error("buffer flag changed too early after write");

  irq_gating_a: assert property (
    tx_irq == $past(tx_buffer_empty_flag_ff && tx_buffer_irq_enable && global_irq_enable && periph_irq_gate))
    else $error("interrupt does not match its gates");

  shifter_flag_a: assert property (
    load |=> !tx_ctrl_rd[ast_pkg::B_SHIFTER_EMPTY])
    else $error("shifter-empty flag not cleared on load");

  nine_bit_a: assert property (
    load && nine_bit_tx_select |=> nbits_ff == ast_pkg::DATA_BITS_NINE
    && tx_shift_reg_ff[8] == $past(ninth_hold_ff))
    else $error("nine-bit frame not loaded");

  reset_value_a: assert property (
    $past(reset) |-> tx_ctrl_rd == ast_pkg::TX_CTRL_RST && baud_divisor_ff == ast_pkg::BAUD_RST)
    else $error("wrong value after reset");

  port_off_a: assert property (
    !port_enable |=> state_ff == ast_pkg::ST_IDLE && tx_out_ff && !hold_full_ff)
    else $error("port disable did not stop transmitter");

  bit_length_a: assert property (
    bit_tick && counting |-> dwell_ff == bit_len_m1)
    else $error("bit period differs from divisor setting");

  oe_release_a: assert property (
    !port_enable |=> !transmit_pin_oe && !receive_pin_oe)
    else $error("pin still driven with port disabled");

  halt_no_run_a: assert property (
    !run |=> shifter_empty_flag && transmit_pin_out)
    else $error("line active while transmission not enabled");

  eight_bit_a: assert property (
    load && !nine_bit_tx_select |=> nbits_ff == ast_pkg::DATA_BITS_STD)
    else $error("eight-bit frame loaded with wrong length");

  // Last stop bit with nothing queued
  sequence last_stop_s;
    state_ff == ast_pkg::ST_STOP && bit_tick && !hold_full_ff && run;
  endsequence

  frame_done_a: assert property (
    last_stop_s |=> shifter_empty_flag && transmit_pin_out)
    else $error("shifter not empty after last stop bit");

endmodule : ast_transmitter
`default_nettype wire

// [tb/ast_rx_model.sv]
// Behavioural remote receiver that decodes frames from the serial line
`timescale 1ns/1ps
`default_nettype none
module ast_rx_model (
  input wire logic mclk,
  input wire logic line,
  input wire logic nine,
  input wire logic [7:0] bit_clks,
  output logic got,
  output logic [8:0] data,
  output logic stop_ok
);
  initial begin
    got = 1'b0;
    data = 9'h000;
    stop_ok = 1'b0;
  end
  // Samples at bit centres, so a wrong bit period drifts out within a frame
  always begin
    @(posedge mclk);
    got <= 1'b0;
    if (line === 1'b0) begin
      repeat (bit_clks / 2) @(posedge mclk);
      // A start bit gone high by its centre is dropped, as a real receiver does
      if (line === 1'b0) begin
        data <= 9'h000;
        for (int i = 0; i < 9; i++) begin
          if (i < 8 || nine) begin
            repeat (bit_clks) @(posedge mclk);
            data[i] <= line;
          end
        end
        repeat (bit_clks) @(posedge mclk);
        stop_ok <= (line === 1'b1);
        got <= 1'b1;
      end
    end
  end
endmodule : ast_rx_model
`default_nettype wire

// [tb/test_ast_transmitter.sv]
// Self-checking bench for the asynchronous serial transmitter
`timescale 1ns/1ps
`default_nettype none
module test_ast_transmitter;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, pin, pin_oe, rx_oe, tx_irq, got, stop_ok;
  logic nine = 1'b0;
  logic [7:0] bit_clks = 8'h10;
  logic [8:0] rx_data;
  logic [8:0] exp_q[$];
  int gaps[$];
  int gap_cnt = 0;
  logic pin_q = 1'b1;
  logic [7:0] lfsr = 8'h2b;
  logic [7:0] cfg_ctrl[4] = '{8'h24, 8'h24, 8'h20, 8'h65};
  logic [7:0] cfg_baud[4] = '{8'h00, 8'h02, 8'h00, 8'h00};
  int fail_count = 0;
  int n_tests = 0;

  always #4 mclk = ~mclk;

  ast_transmitter i_ast_transmitter (.mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .transmit_pin_out(pin), .transmit_pin_oe(pin_oe), .receive_pin_oe(rx_oe),
    .tx_irq(tx_irq));
  // Undriven line rests at the pull-up level
  ast_rx_model i_ast_rx_model (.mclk(mclk), .line(pin_oe ? pin : 1'b1), .nine(nine),
    .bit_clks(bit_clks), .got(got), .data(rx_data), .stop_ok(stop_ok));

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic timed_out();
    fail_count++;
    $display("unexpected at %0t: wait ran out", $time);
    print_verdict();
  endtask : timed_out

  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt

  // One classic cycle; held until ack is sampled, then one idle cycle
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                          output logic [7:0] rd);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h000000, dat};
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (k >= 20) timed_out();
    @(posedge mclk);
  endtask : wb_cycle

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    logic [7:0] rd;
    wb_cycle(1'b1, adr, dat, rd);
  endtask : wr

  task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
    logic [7:0] rd;
    wb_cycle(1'b0, adr, 8'h00, rd);
    check({24'h0, rd}, {24'h0, exp});
  endtask : rd_chk

  task automatic send(input logic [7:0] ch, input logic b9);
    exp_q.push_back({b9, ch});
    wr(ast_pkg::OFS_TX_HOLDING, ch);
  endtask : send

  task automatic drain();
    int k;
    k = 0;
    while (exp_q.size() > 0 && k < 5000) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 5000) timed_out();
    // Frame is decoded at mid stop bit; let the stop bit finish
    repeat (bit_clks) @(posedge mclk);
  endtask : drain

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask : end_test

  // Watcher: every decoded frame is matched against the oldest note
  always @(posedge mclk) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) check(32'h0, 32'h1);
      else check({stop_ok, rx_data}, {1'b1, exp_q.pop_front()});
    end
  end

  // Falling-edge spacing of the line, in clocks
  always @(posedge mclk) begin
    pin_q <= pin;
    gap_cnt <= gap_cnt + 1;
    if (pin_q === 1'b1 && pin === 1'b0) begin
      gaps.push_back(gap_cnt);
      gap_cnt <= 1;
    end
  end

  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    check({rx_oe, pin_oe, pin}, 32'h1);
    for (int a = 0; a < 8; a++) rd_chk(8'(a * 4), a == 0 ? 8'h02 : 8'h00);
    end_test("reset");
    wr(ast_pkg::OFS_PERIPH_FLAGS, 8'hff);
    rd_chk(ast_pkg::OFS_PERIPH_FLAGS, 8'h00);
    wr(ast_pkg::OFS_TX_CTRL_STATUS, 8'hdd);
    rd_chk(ast_pkg::OFS_TX_CTRL_STATUS, 8'hd7);
    wr(ast_pkg::OFS_RX_CTRL_STATUS, 8'h80);
    check({rx_oe, pin_oe, pin}, 32'h3);
    wr(ast_pkg::OFS_TX_CTRL_STATUS, 8'h24);
    rd_chk(ast_pkg::OFS_PERIPH_FLAGS, 8'h10);
    wr(ast_pkg::OFS_PERIPH_IRQ_EN, 8'h10);
    for (int g = 0; g < 4; g++) begin
      wr(ast_pkg::OFS_IRQ_GATES, {g[1:0], 6'h00});
      check({31'h0, tx_irq}, {31'h0, g == 3});
    end
    wr(ast_pkg::OFS_PERIPH_IRQ_EN, 8'h00);
    check({31'h0, tx_irq}, 32'h0);
    rd_chk(ast_pkg::OFS_PERIPH_FLAGS, 8'h10);
    wr(ast_pkg::OFS_PERIPH_IRQ_EN, 8'h10);
    end_test("flags");
    // Back-to-back pair per format; 0x00 first so its frame has no inner fall
    for (int c = 0; c < 4; c++) begin
      wr(ast_pkg::OFS_BAUD_DIVISOR, cfg_baud[c]);
      wr(ast_pkg::OFS_TX_CTRL_STATUS, cfg_ctrl[c]);
      bit_clks = (cfg_ctrl[c][2] ? 8'd16 : 8'd64) * (cfg_baud[c] + 8'd1);
      nine = cfg_ctrl[c][6];
      gaps.delete();
      send(8'h00, nine & cfg_ctrl[c][0]);
      lfsr = nxt(lfsr);
      send(lfsr, nine & cfg_ctrl[c][0]);
      rd_chk(ast_pkg::OFS_PERIPH_FLAGS, 8'h10);
      repeat (10) @(posedge mclk);
      rd_chk(ast_pkg::OFS_PERIPH_FLAGS, 8'h00);
      check({31'h0, tx_irq}, 32'h0);
      rd_chk(ast_pkg::OFS_TX_CTRL_STATUS, cfg_ctrl[c]);
      drain();
      check(gaps.size() > 1 ? gaps[1] : 0, (10 + nine) * bit_clks);
      rd_chk(ast_pkg::OFS_TX_CTRL_STATUS, cfg_ctrl[c] | 8'h02);
      rd_chk(ast_pkg::OFS_PERIPH_FLAGS, 8'h10);
      check({31'h0, tx_irq}, 32'h1);
    end
    end_test("frames");
    nine = 1'b0;
    // Low speed, divisor zero
    bit_clks = 8'd64;
    wr(ast_pkg::OFS_TX_CTRL_STATUS, 8'h30);
    wr(ast_pkg::OFS_TX_HOLDING, 8'ha5);
    repeat (100) @(posedge mclk);
    check({31'h0, pin}, 32'h1);
    exp_q.push_back(9'h0a5);
    wr(ast_pkg::OFS_TX_CTRL_STATUS, 8'h20);
    drain();
    end_test("gating");
    // Long start bit lets the abort land before the receiver's centre sample
    wr(ast_pkg::OFS_TX_HOLDING, 8'h00);
    wr(ast_pkg::OFS_TX_HOLDING, 8'ha5);
    check({31'h0, pin}, 32'h0);
    wr(ast_pkg::OFS_RX_CTRL_STATUS, 8'h00);
    repeat (2) @(posedge mclk);
    check({rx_oe, pin_oe, pin}, 32'h1);
    wr(ast_pkg::OFS_RX_CTRL_STATUS, 8'h80);
    repeat (300) @(posedge mclk);
    check({31'h0, pin}, 32'h1);
    rd_chk(ast_pkg::OFS_TX_CTRL_STATUS, 8'h22);
    end_test("abort");
    print_verdict();
  end
endmodule : test_ast_transmitter
`default_nettype wire
